// file: core/periph_protect_regs.vh
// register map, field positions and reset values of the write-protect controllers
`ifndef PERIPH_PROTECT_REGS_VH
`define PERIPH_PROTECT_REGS_VH

// bus address width and data width
`define PP_ADDR_W              8
`define PP_DATA_W              32

// base of each controller's window in the register address space
`define PP_CTRL_ONE_BASE       8'h00
`define PP_CTRL_TWO_BASE       8'h10
`define PP_BASE_MASK           8'hF0

// views inside one controller's window
`define PP_CLEAR_VIEW_OFS      8'h00
`define PP_SET_VIEW_OFS        8'h04
`define PP_OFS_MASK            8'h0F

// reset values of the two controllers
`define PP_CTRL_ONE_RESET      32'h00000002
`define PP_CTRL_TWO_RESET      32'h00800000

// bits that hold a protection flop; other bits read zero
`define PP_CTRL_ONE_IMPL       32'h0000006E
`define PP_CTRL_TWO_IMPL       32'h009FFFFE

// controller one field positions
`define PP_DEBUG_UNIT_BIT      1
`define PP_FLASH_CTRL_BIT      2
`define PP_PORT_BIT            3
`define PP_USB_BIT             5
`define PP_TRACE_BUFFER_BIT    6

// controller two field positions
`define PP_EVENT_ROUTER_BIT    1
`define PP_SERIAL_LSB          2
`define PP_SERIAL_MSB          7
`define PP_CONTROL_TIMER_LSB   8
`define PP_CONTROL_TIMER_MSB   10
`define PP_BASIC_TIMER_LSB     11
`define PP_BASIC_TIMER_MSB     15
`define PP_ADC_BIT             16
`define PP_COMPARATOR_BIT      17
`define PP_DAC_BIT             18
`define PP_TOUCH_CTRL_BIT      19
`define PP_SOUND_BIT           20
`define PP_SPARE_BIT           23

`endif

// file: core/peripheral_write_protect.v
// two write-protect controllers behind one register port
//
// Notes on behaviour
// R1: writing zero to any protection bit, either view, leaves it unchanged
// R2: writing one in clear view unprotects; reading returns current protection state
// R3: each controller decodes its clear view at offset 0x00
// R4: each controller decodes its set view at 0x04; it reads same bits
// R5: controller two bits 8..10 protect control timers 0..2
// R6: controller two bits 11..15 protect basic timers 3..7 in order
// R7: writing one in set view turns on protection for that peripheral
`timescale 1ns/1ps
`include "periph_protect_regs.vh"
module peripheral_write_protect
#(
   parameter ADDR_W = `PP_ADDR_W
)
(
   input  wire              clk_sys,
   input  wire              rst_b,
   input  wire [ADDR_W-1:0] reg_addr,
   input  wire [31:0]       reg_wdata,
   input  wire              reg_wr,
   input  wire              reg_rd,
   output reg  [31:0]       reg_rdata,
   output wire [31:0]       ctrl_one_protect,
   output wire [31:0]       ctrl_two_protect,
   output wire              debug_unit_protect_bit,
   output wire              flash_ctrl_protect_bit,
   output wire              port_protect_bit,
   output wire              usb_protect_bit,
   output wire              trace_buffer_protect_bit,
   output wire              event_router_protect_bit,
   output wire [5:0]        serial_unit_protect_bit,
   output wire [2:0]        control_timer_protect_bit,
   output wire [4:0]        basic_timer_protect_bit,
   output wire              adc_protect_bit,
   output wire              comparator_protect_bit,
   output wire              dac_protect_bit,
   output wire              touch_ctrl_protect_bit,
   output wire              sound_protect_bit
);

   reg               rst_meta_q;
   reg               rst_sync_b;
   wire [ADDR_W-1:0] base_sel;
   wire [ADDR_W-1:0] ofs_sel;
   wire              hit_one;
   wire              hit_two;
   wire              hit_clear;
   wire              hit_set;
   wire              one_clear_we;
   wire              one_set_we;
   wire              two_clear_we;
   wire              two_set_we;
   wire [31:0]       prot_one;
   wire [31:0]       prot_two;
   reg  [31:0]       rdata_d;

   // reset released through two flops, asserted at once
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_b <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_b <= rst_meta_q;
      end
   end

   // split address into controller window and view offset
   assign base_sel  = reg_addr & `PP_BASE_MASK;
   assign ofs_sel   = reg_addr & `PP_OFS_MASK;
   assign hit_one   = (base_sel == `PP_CTRL_ONE_BASE);
   assign hit_two   = (base_sel == `PP_CTRL_TWO_BASE);
   assign hit_clear = (ofs_sel == `PP_CLEAR_VIEW_OFS);    // [R3]
   assign hit_set   = (ofs_sel == `PP_SET_VIEW_OFS);      // [R4]

   // write strobes per controller and view; other addresses are dropped
   assign one_clear_we = reg_wr && hit_one && hit_clear;  // [R3]
   assign one_set_we   = reg_wr && hit_one && hit_set;    // [R4]
   assign two_clear_we = reg_wr && hit_two && hit_clear;  // [R3]
   assign two_set_we   = reg_wr && hit_two && hit_set;    // [R4]

   // controller one: debug, flash, port, usb, trace buffer
   protect_bank
   #(
      .WIDTH     (32),
      .RESET_VAL (`PP_CTRL_ONE_RESET),
      .IMPL_MASK (`PP_CTRL_ONE_IMPL)
   )
   u_ctrl_one
   (
      .clk_sys    (clk_sys),
      .rst_sync_b (rst_sync_b),
      .clear_we   (one_clear_we),
      .set_we     (one_set_we),
      .wdata      (reg_wdata),
      .protect_q  (prot_one)
   );

   // controller two: event router, serial units, timers, analog, sound
   protect_bank
   #(
      .WIDTH     (32),
      .RESET_VAL (`PP_CTRL_TWO_RESET),
      .IMPL_MASK (`PP_CTRL_TWO_IMPL)
   )
   u_ctrl_two
   (
      .clk_sys    (clk_sys),
      .rst_sync_b (rst_sync_b),
      .clear_we   (two_clear_we),
      .set_we     (two_set_we),
      .wdata      (reg_wdata),
      .protect_q  (prot_two)
   );

   // read data: both views show the same protection state
   always @*
   begin
      rdata_d = 32'h00000000;                            // unmapped reads zero
      if (reg_rd && (hit_clear || hit_set))
      begin
         if (hit_one)
            rdata_d = prot_one;                          // [R2] [R4]
         else if (hit_two)
            rdata_d = prot_two;                          // [R2] [R4]
      end
   end

   // read data stands for the one cycle after the read strobe
   always @(posedge clk_sys or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
         reg_rdata <= 32'h00000000;
      else
         reg_rdata <= rdata_d;
   end

   // whole protection vectors, straight from the bank flops
   assign ctrl_one_protect = prot_one;
   assign ctrl_two_protect = prot_two;

   // controller one per-peripheral protection levels
   assign debug_unit_protect_bit   = prot_one[`PP_DEBUG_UNIT_BIT];
   assign flash_ctrl_protect_bit   = prot_one[`PP_FLASH_CTRL_BIT];
   assign port_protect_bit         = prot_one[`PP_PORT_BIT];
   assign usb_protect_bit          = prot_one[`PP_USB_BIT];
   assign trace_buffer_protect_bit = prot_one[`PP_TRACE_BUFFER_BIT];

   // controller two per-peripheral protection levels
   assign event_router_protect_bit = prot_two[`PP_EVENT_ROUTER_BIT];
   assign serial_unit_protect_bit  = prot_two[`PP_SERIAL_MSB:`PP_SERIAL_LSB];
   // control timers 0..2 on bits 8..10
   assign control_timer_protect_bit =
      prot_two[`PP_CONTROL_TIMER_MSB:`PP_CONTROL_TIMER_LSB];  // [R5]
   // basic timers 3..7 on bits 11..15, timer 3 lowest
   assign basic_timer_protect_bit =
      prot_two[`PP_BASIC_TIMER_MSB:`PP_BASIC_TIMER_LSB];      // [R6]
   assign adc_protect_bit          = prot_two[`PP_ADC_BIT];
   assign comparator_protect_bit   = prot_two[`PP_COMPARATOR_BIT];
   assign dac_protect_bit          = prot_two[`PP_DAC_BIT];
   assign touch_ctrl_protect_bit   = prot_two[`PP_TOUCH_CTRL_BIT];
   assign sound_protect_bit        = prot_two[`PP_SOUND_BIT];

endmodule

// file: core/protect_bank.v
// one bank of write-protection flops with clear and set write views
`timescale 1ns/1ps
module protect_bank
#(
   parameter               WIDTH     = 32,
   parameter [WIDTH-1:0]   RESET_VAL = {WIDTH{1'b0}},
   parameter [WIDTH-1:0]   IMPL_MASK = {WIDTH{1'b1}}
)
(
   input  wire             clk_sys,
   input  wire             rst_sync_b,
   input  wire             clear_we,
   input  wire             set_we,
   input  wire [WIDTH-1:0] wdata,
   output wire [WIDTH-1:0] protect_q
);

   genvar i;

   // one flop per bit; unimplemented bits are constant zero
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_bit
         if (IMPL_MASK[i])
         begin : g_impl
            reg bit_q;
            reg bit_d;

            // a one clears or sets, a zero keeps the state
            always @*
            begin
               bit_d = bit_q;
               if (clear_we && wdata[i])
                  bit_d = 1'b0;                // [R2]
               else if (set_we && wdata[i])
                  bit_d = 1'b1;                // [R7]
            end                                // zero written keeps state [R1]

            always @(posedge clk_sys or negedge rst_sync_b)
            begin
               if (!rst_sync_b)
                  bit_q <= RESET_VAL[i];
               else
                  bit_q <= bit_d;
            end

            assign protect_q[i] = bit_q;
         end
         else
         begin : g_none
            assign protect_q[i] = 1'b0;
         end
      end
   endgenerate

endmodule

// file: dv/pwp_monitor.sv
// concurrent checks on the protect register port and protect outputs
`timescale 1ns/1ps
module pwp_monitor
(
   input wire logic        clk_sys,
   input wire logic        rst_b,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [31:0] ctrl_one_protect,
   input wire logic [31:0] ctrl_two_protect,
   input wire logic [2:0]  control_timer_protect_bit,
   input wire logic [4:0]  basic_timer_protect_bit
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // any write into controller two's window
   sequence wr_two;
      reg_wr && reg_addr[7:4] == 4'h1;
   endsequence
   AST_ZERO_KEEP:
   assert property (wr_two |=> (ctrl_two_protect & ~$past(reg_wdata))
      == ($past(ctrl_two_protect) & ~$past(reg_wdata))) else $error("zero bit changed");
   AST_CLR_VIEW:
   assert property (reg_wr && reg_addr == 8'h10 |=> (ctrl_two_protect & $past(reg_wdata))
      == 32'h0) else $error("clear view missed");
   AST_SET_VIEW:
   assert property (reg_wr && reg_addr == 8'h14 |=> (~ctrl_two_protect & $past(reg_wdata)
      & 32'h009FFFFE) == 32'h0) else $error("set view missed");
   AST_CLR_OFS:
   assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata == $past(ctrl_two_protect))
      else $error("clear view read wrong");
   AST_SET_OFS:
   assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata == $past(ctrl_one_protect))
      else $error("set view read wrong");
   AST_CTRL_TIMERS:
   assert property (control_timer_protect_bit == ctrl_two_protect[10:8])
      else $error("control timer bits misplaced");
   AST_BASIC_TIMERS:
   assert property (basic_timer_protect_bit == ctrl_two_protect[15:11])
      else $error("basic timer bits misplaced");
   AST_ONE_HOLD:
   assert property (!reg_wr |=> $stable(ctrl_one_protect)) else $error("protect drifted");
endmodule
bind peripheral_write_protect pwp_monitor u_mon (.clk_sys, .rst_b, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .ctrl_one_protect, .ctrl_two_protect,
   .control_timer_protect_bit, .basic_timer_protect_bit);

// file: dv/tb_peripheral_write_protect.sv
// self-checking bench for the two write-protect controllers
`timescale 1ns/1ps
module tb_peripheral_write_protect;
   logic        clk_sys = 0;
   logic        rst_b = 0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 0;
   logic        reg_rd = 0;
   wire  [31:0] reg_rdata, ctrl_one_protect, ctrl_two_protect;
   wire  [2:0]  control_timer_protect_bit;
   wire  [4:0]  basic_timer_protect_bit;
   wire         debug_unit_protect_bit;
   wire         flash_ctrl_protect_bit, port_protect_bit, usb_protect_bit;
   wire         trace_buffer_protect_bit, event_router_protect_bit;
   wire  [5:0]  serial_unit_protect_bit;
   wire         adc_protect_bit, comparator_protect_bit, dac_protect_bit;
   wire         touch_ctrl_protect_bit, sound_protect_bit;
   int          failures = 0;
   int          compares = 0;
   // rows: write address, write data, read address, expected read data
   logic [79:0] rows [8] = '{
      {8'h04, 32'h0000006E, 8'h00, 32'h0000006E},
      {8'h00, 32'h00000000, 8'h04, 32'h0000006E},
      {8'h00, 32'h00000024, 8'h00, 32'h0000004A},
      {8'h14, 32'h00000700, 8'h10, 32'h00800700},
      {8'h14, 32'h0000F800, 8'h14, 32'h0080FF00},
      {8'h10, 32'h00000500, 8'h14, 32'h0080FA00},
      {8'h18, 32'hFFFFFFFF, 8'h18, 32'h00000000},
      {8'h14, 32'hFFFFFFFF, 8'h10, 32'h009FFFFE}};
   always #10 clk_sys = ~clk_sys;
   peripheral_write_protect u_dut (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .ctrl_one_protect, .ctrl_two_protect, .debug_unit_protect_bit,
      .flash_ctrl_protect_bit, .port_protect_bit, .usb_protect_bit,
      .trace_buffer_protect_bit, .event_router_protect_bit, .serial_unit_protect_bit,
      .control_timer_protect_bit, .basic_timer_protect_bit, .adc_protect_bit,
      .comparator_protect_bit, .dac_protect_bit, .touch_ctrl_protect_bit,
      .sound_protect_bit);
   // bus cycles, each driven just after a rising edge
   task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // read, then look at the data in the following cycle
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      bus(0, 1, a, 32'h0);
      bus(0, 0, a, 32'h0);
      @(negedge clk_sys);
      chk(reg_rdata, exp);
   endtask
   task automatic summarize;
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd_chk(8'h04, 32'h00000002);
      rd_chk(8'h10, 32'h00800000);
      chk({31'h0, debug_unit_protect_bit}, 32'h1);
      // write then read back to back
      for (int i = 0; i < 8; i++)
      begin
         bus(1, 0, rows[i][79:72], rows[i][71:40]);
         rd_chk(rows[i][39:32], rows[i][31:0]);
      end
      @(negedge clk_sys);
      chk(reg_rdata, 32'h0);
      chk(ctrl_one_protect, 32'h0000004A);
      chk({29'h0, control_timer_protect_bit}, 32'h7);
      chk({27'h0, basic_timer_protect_bit}, 32'h1F);
      // per-peripheral levels: controller one holds 0x4A, controller two 0x009FFFFE
      chk({27'h0, debug_unit_protect_bit, flash_ctrl_protect_bit, port_protect_bit,
         usb_protect_bit, trace_buffer_protect_bit}, 32'h00000015);
      chk({20'h0, event_router_protect_bit, serial_unit_protect_bit, adc_protect_bit,
         comparator_protect_bit, dac_protect_bit, touch_ctrl_protect_bit,
         sound_protect_bit}, 32'h00000FFF);
      // second reset in mid-run restores both controllers
      @(posedge clk_sys);
      rst_b <= 1'b0;
      @(negedge clk_sys);
      chk(ctrl_one_protect, 32'h00000002);
      chk(ctrl_two_protect, 32'h00800000);
      @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd_chk(8'h14, 32'h00800000);
      rd_chk(8'h00, 32'h00000002);
      summarize;
   end
endmodule
